/* File: design/supply_monitor.sv */
// supply monitor and boost control register block
// assumes: analog comparators and 32 khz clock arrive asynchronously on pins
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module supply_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic ce,
  input wire logic [supply_monitor_pkg::addr_w-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic dig_low,
  input wire logic ana_low,
  input wire logic dig_high,
  input wire logic ana_high,
  input wire logic [4:0] boost_cmp,
  input wire logic clk32k,
  input wire logic sleep,
  input wire logic awake,
  output logic supply_monitor_interrupt,
  output logic protected_reset_path,
  output logic boost_switch,
  output logic boost_switch_oe,
  output logic [4:0] boost_vsel,
  output logic boost_run
);
  import supply_monitor_pkg::*;
  // ************************************************************
  // pin synchronisers: three stages, change when stages 2 and 3 agree
  // ************************************************************
  localparam int unsigned np = 10;
  logic [np-1:0] pin_in;
  logic [np-1:0] s1_r;
  logic [np-1:0] s2_r;
  logic [np-1:0] s3_r;
  logic [np-1:0] pin_r;
  logic [np-1:0] pin_nxt;
  assign pin_in = {clk32k, boost_cmp, ana_high, dig_high, ana_low, dig_low};
  // stages 2 and 3 agree: take it, else hold
  assign pin_nxt = (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
    end else if (ce) begin
      s1_r <= pin_in;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s2_r <= '0;
    end else if (ce) begin
      s2_r <= s1_r;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s3_r <= '0;
    end else if (ce) begin
      s3_r <= s2_r;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_r <= '0;
    end else if (ce) begin
      pin_r <= pin_nxt;
    end
  end
  // ************************************************************
  // conditioned pins
  // ************************************************************
  logic dl;
  logic al;
  logic dh;
  logic ah;
  logic [4:0] cmp;
  logic k32;
  assign dl = pin_r[0];
  assign al = pin_r[1];
  assign dh = pin_r[2];
  assign ah = pin_r[3];
  assign cmp = pin_r[8:4];
  assign k32 = pin_r[9];
  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] vmode_r;
  logic [7:0] enfreq_r;
  logic [7:0] auto_r;
  logic [7:0] trip_r;
  logic [7:0] ctrl_r;
  logic [7:0] rsel_r;
  logic [2:0] sticky_r;
  logic ack_r;
  logic wait_r;
  wire ovsel = ctrl_r[ov_sel_bit];
  wire den = ctrl_r[dig_en_bit];
  wire aen = ctrl_r[ana_en_bit];
  wire oen = ctrl_r[ov_en_bit];
  wire ov_mon = ovsel ? ah : dh;
  // ************************************************************
  // bus decode
  // ************************************************************
  wire req = (read | write) & ~ack_r;
  wire wr = write & req;
  wire rd = read & req;
  wire hit_vm = address == boost_voltage_mode_and_pulse_off;
  wire hit_ef = address == boost_enable_and_frequency_off;
  wire hit_ap = address == boost_auto_pulse_control_off;
  wire hit_bs = address == boost_output_level_status_off;
  wire hit_tl = address == undervoltage_trip_levels_off;
  wire hit_ct = address == voltage_monitor_control_off;
  wire hit_rs = address == undervoltage_reset_select_off;
  wire hit_st = address == sticky_monitor_status_off;
  wire [7:0] wd = writedata[7:0];
  wire [2:0] live = {ov_mon & oen, al & aen, dl & den};
  // ************************************************************
  // sticky status: set wins over clear
  // ************************************************************
  wire st_rd = rd & hit_st;
  wire st_wr = wr & hit_st;
  wire [2:0] clr = {st_rd | st_wr, st_rd, st_rd};
  logic [2:0] sticky_nxt;
  assign sticky_nxt = (sticky_r & ~clr) | live;
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      sticky_r <= 3'h0;
    end else if (ce) begin
      sticky_r <= sticky_nxt;
    end
  end
  // ************************************************************
  // read data
  // ************************************************************
  logic [7:0] rdmux;
  assign rdmux = hit_vm ? vmode_r :
                 hit_ef ? enfreq_r :
                 hit_ap ? auto_r :
                 hit_bs ? {3'h0, cmp} :
                 hit_tl ? trip_r :
                 hit_ct ? ctrl_r :
                 hit_rs ? rsel_r :
                 hit_st ? {1'b0, live, 1'b0, sticky_r} : 8'h00;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0;
    end else if (ce && rd) begin
      readdata <= {24'h0, rdmux};
    end
  end
  // ************************************************************
  // bus handshake
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else if (ce) begin
      ack_r <= req;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
    end else if (ce) begin
      wait_r <= ~req;
    end
  end
  assign waitrequest = wait_r;
  // ************************************************************
  // control register next values
  // ************************************************************
  logic thump_done;
  logic [7:0] vmode_nxt;
  logic [7:0] enfreq_nxt;
  logic [7:0] auto_nxt;
  logic [7:0] trip_nxt;
  logic [7:0] ctrl_nxt;
  logic [7:0] rsel_nxt;
  always_comb begin
    vmode_nxt = vmode_r;
    if (wr && hit_vm) begin
      vmode_nxt = wd;
    end
    if (thump_done) begin
      vmode_nxt[thump_bit] = 1'b0;
    end
  end
  assign enfreq_nxt = (wr && hit_ef) ? wd : enfreq_r;
  assign auto_nxt = (wr && hit_ap) ? wd : auto_r;
  assign trip_nxt = (wr && hit_tl) ? wd : trip_r;
  assign ctrl_nxt = (wr && hit_ct) ? wd : ctrl_r;
  assign rsel_nxt = (wr && hit_rs) ? wd : rsel_r;
  // ************************************************************
  // control register storage
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vmode_r <= vmode_reset;
    end else if (ce) begin
      vmode_r <= vmode_nxt;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enfreq_r <= enfreq_reset;
    end else if (ce) begin
      enfreq_r <= enfreq_nxt;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_r <= zero_reset;
    end else if (ce) begin
      auto_r <= auto_nxt;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_r <= zero_reset;
    end else if (ce) begin
      trip_r <= trip_nxt;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= zero_reset;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsel_r <= zero_reset;
    end else if (ce) begin
      rsel_r <= rsel_nxt;
    end
  end
  // ************************************************************
  // interrupt and reset outputs
  // ************************************************************
  wire [1:0] lv_irq = sticky_r[1:0] & {aen & ~rsel_r[7], den & ~rsel_r[6]};
  wire irq_any = |lv_irq | (sticky_r[2] & oen);
  logic irq_r;
  logic prst_r;
  logic irq_nxt;
  logic prst_nxt;
  assign irq_nxt = irq_any & awake;
  assign prst_nxt = (al & aen & rsel_r[7]) | (dl & den & rsel_r[6]);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= irq_nxt;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prst_r <= 1'b0;
    end else if (ce) begin
      prst_r <= prst_nxt;
    end
  end
  assign supply_monitor_interrupt = irq_r;
  assign protected_reset_path = prst_r;
  // ************************************************************
  // boost mode decode
  // ************************************************************
  wire [1:0] bmode = vmode_r[6:5];
  wire ben = enfreq_r[boost_en_bit];
  wire act = ben & (bmode == mode_active) & ~sleep;
  wire stby = ben & (bmode == mode_standby) & ~sleep;
  logic [15:0] div_r;
  logic [15:0] pcnt_r;
  logic sw_r;
  logic k32_d_r;
  logic oe_r;
  wire [15:0] half = enfreq_r[1:0] == 2'h0 ? 16'(div_2m) :
                     enfreq_r[1:0] == 2'h1 ? 16'(div_500k) : 16'(div_125k);
  wire below = cmp[1];
  wire edge32 = k32 ^ k32_d_r;
  wire thump_go = stby & vmode_r[thump_bit] & (pcnt_r == 16'h0) & ~sw_r;
  wire auto_go = stby & auto_r[0] & edge32 & below & (pcnt_r == 16'h0);
  assign thump_done = vmode_r[thump_bit] & (~stby | thump_go);
  wire div_wrap = div_r + 16'h1 >= half;
  // ************************************************************
  // switch pulse generator
  // ************************************************************
  logic [15:0] div_nxt;
  logic [15:0] pcnt_nxt;
  logic sw_nxt;
  always_comb begin
    div_nxt = div_r;
    pcnt_nxt = 16'h0;
    sw_nxt = 1'b0;
    if (act) begin
      div_nxt = div_wrap ? 16'h0 : div_r + 16'h1;
      pcnt_nxt = pcnt_r;
      sw_nxt = div_wrap ? ~sw_r : sw_r;
    end else if (thump_go) begin
      pcnt_nxt = 16'(thump_cycles);
      sw_nxt = 1'b1;
    end else if (auto_go) begin
      pcnt_nxt = 16'(auto_pulse_cycles);
      sw_nxt = 1'b1;
    end else if (pcnt_r > 16'h1 && stby) begin
      pcnt_nxt = pcnt_r - 16'h1;
      sw_nxt = sw_r;
    end
  end
  // ************************************************************
  // boost state
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 16'h0;
    end else if (ce) begin
      div_r <= div_nxt;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pcnt_r <= 16'h0;
    end else if (ce) begin
      pcnt_r <= pcnt_nxt;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_r <= 1'b0;
    end else if (ce) begin
      sw_r <= sw_nxt;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      k32_d_r <= 1'b0;
    end else if (ce) begin
      k32_d_r <= k32;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_r <= 1'b0;
    end else if (ce) begin
      oe_r <= ben & ~sleep;
    end
  end
  // ************************************************************
  // boost outputs
  // ************************************************************
  logic [4:0] vsel_r;
  logic run_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vsel_r <= vmode_reset[4:0];
    end else if (ce) begin
      vsel_r <= vmode_r[4:0];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 1'b0;
    end else if (ce) begin
      run_r <= ben & ~sleep;
    end
  end
  assign boost_switch = sw_r;
  assign boost_switch_oe = oe_r;
  assign boost_vsel = vsel_r;
  assign boost_run = run_r;
endmodule : supply_monitor

/* File: design/supply_monitor_pkg.sv */
// package: constants for the supply monitor and boost control block
// assumes: 100 mhz bus clock, avalon-mm register access with 32-bit words
// Notes on behaviour
// - undervoltage detectors off after reset; trip 1.7 V to 5.45 V in 250 mV steps.
// - analog undervoltage detector enabled by control bit 1, threshold in bits 7:4.
// - digital undervoltage detector enabled by control bit 0, threshold in bits 3:0.
// - undervoltage sticky bit sets on low supply, cleared by status read or power-on reset.
// - status bits update whenever a detector is enabled, interrupt used or not.
// - live status bit shows each undervoltage condition present right now.
// - reset-select bits 7:6 turn an enabled detector into a protected reset source.
// - undervoltage interrupt only when enabled and reset-select bit clear.
// - one overvoltage detector, 5.75 V fixed, control bit 3 picks analog or digital.
// - overvoltage detector off after reset, enabled and unmasked by control bit 2.
// - overvoltage sticky bit cleared by status read or write, or power-on reset.
// - live status bit shows overvoltage condition still present.
// - combined interrupt is OR of three sticky bits; software clears all three.
// - detection during sleep sampling waits for wakeup before interrupt is raised.
// - boost enable bit 3, voltage field bits 4:0; enabled at 1.8 V after startup.
// - boost mode active or standby in bits 6:5 of voltage and mode register.
// - active mode frequency select bits 1:0: 2 MHz, 500 kHz, 125 kHz.
// - thump bit 7 in standby gives one 1 us transistor pulse.
// - auto pulse mode bit 0 pulses on each 32 kHz edge while output is low.
// - boost status reports five comparator results in bits 4:0.
// - in sleep boost comparators off and boost output high impedance.
package supply_monitor_pkg;
  localparam int unsigned clk_mhz = 100;
  localparam int unsigned addr_w = 5;
  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [addr_w-1:0] boost_voltage_mode_and_pulse_off = 5'h00;
  localparam logic [addr_w-1:0] boost_enable_and_frequency_off = 5'h04;
  localparam logic [addr_w-1:0] boost_auto_pulse_control_off = 5'h08;
  localparam logic [addr_w-1:0] boost_output_level_status_off = 5'h0c;
  localparam logic [addr_w-1:0] undervoltage_trip_levels_off = 5'h10;
  localparam logic [addr_w-1:0] voltage_monitor_control_off = 5'h14;
  localparam logic [addr_w-1:0] undervoltage_reset_select_off = 5'h18;
  localparam logic [addr_w-1:0] sticky_monitor_status_off = 5'h1c;
  // live status shares the sticky word, bits 6:4
  // ************************************************************
  // fields and reset values
  // ************************************************************
  localparam int unsigned dig_en_bit = 0;
  localparam int unsigned ana_en_bit = 1;
  localparam int unsigned ov_en_bit = 2;
  localparam int unsigned ov_sel_bit = 3;
  localparam int unsigned boost_en_bit = 3;
  localparam int unsigned thump_bit = 7;
  localparam logic [1:0] mode_active = 2'h1;
  localparam logic [1:0] mode_standby = 2'h2;
  localparam logic [7:0] vmode_reset = 8'h20; // 1.8 V code, active mode
  localparam logic [7:0] enfreq_reset = 8'h08;
  localparam logic [7:0] zero_reset = 8'h00;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned thump_ns = 1000;
  localparam int unsigned thump_cycles = (thump_ns * clk_mhz + 999) / 1000;
  localparam int unsigned f2m_khz = 2000;
  localparam int unsigned f500_khz = 500;
  localparam int unsigned f125_khz = 125;
  localparam int unsigned div_2m = clk_mhz * 1000 / f2m_khz / 2;
  localparam int unsigned div_500k = clk_mhz * 1000 / f500_khz / 2;
  localparam int unsigned div_125k = clk_mhz * 1000 / f125_khz / 2;
  localparam int unsigned auto_pulse_ns = 100;
  localparam int unsigned auto_pulse_cycles = auto_pulse_ns * clk_mhz / 1000;
endpackage : supply_monitor_pkg

/* File: bench/supply_monitor_properties.sv */
// checker: bus answer, interrupt, reset request and boost pin timing
// assumes: bound into supply_monitor, ce held high
`timescale 1ns/1ps
module supply_monitor_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic dig_low,
  input wire logic ana_low,
  input wire logic sleep,
  input wire logic awake,
  input wire logic supply_monitor_interrupt,
  input wire logic protected_reset_path,
  input wire logic boost_switch,
  input wire logic boost_switch_oe,
  input wire logic [4:0] boost_vsel,
  input wire logic boost_run
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !por_n);
  logic [3:0] since_low_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) since_low_r <= 4'hf;
    else if (dig_low || ana_low) since_low_r <= 4'h0;
    else if (since_low_r != 4'hf) since_low_r <= since_low_r + 4'h1;
  end
  property p_wait_ans; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("request not answered next cycle");
  property p_irq_rst; $rose(rst_n) |-> !supply_monitor_interrupt; endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("interrupt up after reset");
  property p_boost_rst; $rose(rst_n) |-> ##[0:2] (boost_run && boost_vsel == 5'h00); endproperty
  a_boost_rst: assert property (p_boost_rst) else $error("boost not on at start code");
  property p_rst_path; protected_reset_path |-> since_low_r < 4'h8; endproperty
  a_rst_path: assert property (p_rst_path) else $error("reset request without low supply");
  property p_sleep_hiz; sleep [*8] |-> !boost_switch_oe; endproperty
  a_sleep_hiz: assert property (p_sleep_hiz) else $error("boost output driven in sleep");
  property p_thump_len; $rose(boost_switch) |=> boost_switch [*7]; endproperty
  a_thump_len: assert property (p_thump_len) else $error("switch pulse too short");
  property p_irq_fall;
    $fell(supply_monitor_interrupt) |-> $past(!waitrequest) || $past(!waitrequest, 2) || $past(!waitrequest, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without status access");
  property p_irq_awake; $rose(supply_monitor_interrupt) |-> awake; endproperty
  a_irq_awake: assert property (p_irq_awake) else $error("interrupt raised before wakeup");
endmodule : supply_monitor_properties
bind supply_monitor supply_monitor_properties supply_monitor_properties_i (.clk, .rst_n, .por_n, .read, .write,
  .waitrequest, .dig_low, .ana_low, .sleep, .awake, .supply_monitor_interrupt, .protected_reset_path, .boost_switch,
  .boost_switch_oe, .boost_vsel, .boost_run);

/* File: bench/tb_top.sv */
// testbench: register model, detectors, reset select, thump and switching
// assumes: supply_monitor with bound checker, 100 mhz clock
`timescale 1ns/1ps
module tb_top;
  import supply_monitor_pkg::*;
  logic clk = 0, rst_n = 0, por_n = 0, read = 0, write = 0, dig_low = 0, ana_low = 0, dig_high = 0, ana_high = 0;
  logic clk32k = 0, sleep = 0, awake = 1, waitrequest, irq, rpath, sw, sw_oe, run;
  logic [addr_w-1:0] address = '0;
  logic [31:0] writedata = '0, readdata, rd;
  logic [4:0] boost_cmp = '0, boost_vsel;
  int errors = 0, tests_run = 0, cyc = 0, n, mdl [8], dv [3];
  supply_monitor supply_monitor_i (.clk, .rst_n, .por_n, .ce(1'b1), .address, .read, .write, .writedata, .readdata,
    .waitrequest, .dig_low, .ana_low, .dig_high, .ana_high, .boost_cmp, .clk32k, .sleep, .awake,
    .supply_monitor_interrupt(irq), .protected_reset_path(rpath), .boost_switch(sw), .boost_switch_oe(sw_oe),
    .boost_vsel, .boost_run(run));
  // ************************************************************
  // tasks
  // ************************************************************
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors = errors + 1;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wt(int k);
    repeat (k) @(posedge clk);
  endtask : wt
  task automatic bus(logic wr, logic [addr_w-1:0] a, logic [7:0] d);
    read <= !wr; write <= wr; address <= a; writedata <= {24'h0, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0; write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rdchk(logic [addr_w-1:0] a, logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), rd, {24'h0, e});
  endtask : rdchk
  task automatic det(logic [3:0] p, int k);
    {ana_high, dig_high, ana_low, dig_low} <= p;
    wt(k);
  endtask : det
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    n = $urandom(32'haac1);
    boost_cmp <= 5'($urandom);
    mdl = '{8'h20, 8'h08, 0, 0, 0, 0, 0, 0};
    dv = '{div_2m, div_500k, div_125k};
    wt(2);
    rst_n <= 1'b1; por_n <= 1'b1;
    wt(8);
    for (int i = 0; i < 8; i++) if (i != 3) rdchk(5'(i * 4), 8'(mdl[i]));
    rdchk(5'h0c, {3'h0, boost_cmp});
    rdchk(5'h03, 8'h00);
    for (int i = 0; i < 7; i++) if (i != 3) begin
      mdl[i] = $urandom & ((i == 0) ? 'h7f : 'hff);
      bus(1'b1, 5'(i * 4), 8'(mdl[i]));
      rdchk(5'(i * 4), 8'(mdl[i]));
    end
    bus(1'b1, 5'h18, 8'h00);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, 5'h14, 8'(1 << k));
      det(4'h3, 10);
      rdchk(5'h1c, 8'(8'h11 << k));
      chk("irq", irq, 1);
      det(4'h0, 8);
      rdchk(5'h1c, 8'(1 << k));
      rdchk(5'h1c, 8'h00);
      wt(2);
      chk("irq", irq, 0);
    end
    bus(1'b1, 5'h14, 8'h04);
    det(4'hc, 10);
    rdchk(5'h1c, 8'h44);
    det(4'h0, 8);
    bus(1'b1, 5'h1c, 8'h00);
    wt(2);
    chk("irq", irq, 0);
    rdchk(5'h1c, 8'h00);
    bus(1'b1, 5'h14, 8'h0c);
    det(4'h4, 10);
    rdchk(5'h1c, 8'h00);
    det(4'h8, 10);
    rdchk(5'h1c, 8'h44);
    det(4'h0, 8);
    bus(1'b1, 5'h1c, 8'h00);
    bus(1'b1, 5'h18, 8'hc0);
    bus(1'b1, 5'h14, 8'h03);
    det(4'h1, 3);
    for (n = 0; rpath !== 1'b1 && n < 10; n++) @(posedge clk);
    chk("rpath", rpath, 1);
    chk("irq", irq, 0);
    det(4'h0, 8);
    chk("rpath", rpath, 0);
    rdchk(5'h1c, 8'h01);
    bus(1'b1, 5'h18, 8'h00);
    awake <= 1'b0;
    det(4'h1, 10);
    det(4'h0, 4);
    chk("irq", irq, 0);
    awake <= 1'b1;
    wt(8);
    chk("irq", irq, 1);
    rdchk(5'h1c, 8'h01);
    bus(1'b1, 5'h14, 8'h00);
    bus(1'b1, 5'h04, 8'h08);
    bus(1'b1, 5'h00, 8'hc0);
    while (sw !== 1'b1) @(posedge clk);
    for (n = 0; sw === 1'b1 && n < 300; n++) @(posedge clk);
    chk("thump", n, thump_cycles);
    rdchk(5'h00, 8'h40);
    bus(1'b1, 5'h00, 8'h20);
    for (int f = 0; f < 3; f++) begin
      bus(1'b1, 5'h04, 8'(8'h08 | f));
      repeat (2) begin
        while (sw !== 1'b1) @(posedge clk);
        while (sw !== 1'b0) @(posedge clk);
        for (n = 0; sw !== 1'b1; n++) @(posedge clk);
      end
      chk("half period", n, dv[f]);
    end
    boost_cmp <= 5'h02;
    bus(1'b1, 5'h08, 8'h01);
    bus(1'b1, 5'h00, 8'h45);
    wt(8);
    chk("vsel", boost_vsel, 5'h05);
    chk("run", run, 1);
    for (int e = 0; e < 2; e++) begin
      clk32k <= !clk32k;
      while (sw !== 1'b1) @(posedge clk);
      for (n = 0; sw === 1'b1 && n < 300; n++) @(posedge clk);
      chk("auto pulse", n, auto_pulse_cycles);
    end
    chk("oe", sw_oe, 1);
    sleep <= 1'b1;
    wt(10);
    chk("oe", sw_oe, 0);
    chk("run", run, 0);
    summarize();
  end
endmodule : tb_top
